// ==== core/charger_pkg.sv ====
// Constants, register map and carrier types for the charger register bank
//
// Overview of operation
// - Adapter bit 6 writable, one turns aux regulator off
// - Adapter bit 5 one forces fixed 34mV sense target
// - Adapter bit 4 read-only, shows dedicated adapter detected
// - Adapter bits 2:0 writable adapter input regulation select
// - Safety bit 7 always reads zero
// - Safety bits 6:4 cap effective charge current code
// - Safety bits 3:0 cap effective float voltage code
// - Monitor register at 10h, read-only live status
// - Monitor bit 7 shows termination comparator
// - Monitor bit 6 shows battery voltage comparator
// - Monitor bit 5 shows trickle linear charging active
// - Monitor bit 4 thermal; limits current without high flag
// - Monitor bit 3 zero when charge loop controls
// - Monitor bit 2 zero when input loop controls
// - Monitor bit 1 shows input supply validated
// - Monitor bit 0 shows constant voltage loop control
// - Parameter reset restores adapter default only; safety and interrupt registers kept
package charger_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int          ADDR_W    = 8;
	localparam int          DATA_W    = 32;
	localparam int          IDX_W     = 6;
	localparam int          IDX_LSB   = 2;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLV  = 2'h2;

	// ----------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_ADAPTER   = 6'h05;
	localparam logic [IDX_W-1:0] IDX_SAFETY    = 6'h06;
	localparam logic [IDX_W-1:0] IDX_MONITOR   = 6'h10;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 6'h11;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 6'h12;
	localparam logic [IDX_W-1:0] IDX_PARAM_CMD = 6'h13;

	// ----------------------------------------
	// Field positions, masks and reset values
	// ----------------------------------------
	localparam int         ADP_AUX_OFF    = 6;
	localparam int         ADP_FIXED_SNS  = 5;
	localparam int         ADP_ACTIVE     = 4;
	localparam int         ADP_DIS_PIN    = 3;
	localparam int         ADP_VREG_LSB   = 0;
	localparam int         ADP_VREG_W     = 3;
	localparam int         PARAM_RST_BIT  = 0;
	localparam logic [7:0] ADP_WR_MASK    = 8'h67;
	localparam logic [7:0] ADP_RESET      = 8'h24;
	localparam logic [7:0] SAFETY_RESET   = 8'h40;
	localparam int         CUR_W          = 3;
	localparam int         VFLOAT_W       = 6;
	localparam int         VCEIL_W        = 4;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic       reserved;
		logic [2:0] charge_current_ceiling;
		logic [3:0] float_voltage_ceiling;
	} safety_t;

	typedef struct packed {
		logic termination_compare;
		logic battery_voltage_compare;
		logic trickle_linear_active;
		logic thermal_regulation;
		logic charge_loop_flag;
		logic input_loop_flag;
		logic input_supply_ok;
		logic constant_voltage_flag;
	} monitor_t;

endpackage : charger_pkg

// ==== core/sync2.sv ====
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : sync2
`default_nettype wire

// ==== core/charger_config_status_regs.sv ====
// AXI4-Lite register bank for charger adapter, safety and loop monitor registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module charger_config_status_regs (
	// Clock and reset
	input  wire logic                              mclk,
	input  wire logic                              rst,
	// AXI4-Lite write address
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [charger_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic [2:0]                        s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	input  wire logic [charger_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	// AXI4-Lite write response
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	output logic [1:0]                             s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	input  wire logic [charger_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic [2:0]                        s_axi_arprot,
	// AXI4-Lite read data
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	output logic [charger_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	// Analog status, asynchronous
	input  wire charger_pkg::monitor_t             loop_status,
	input  wire logic                              dedicated_adapter_detected,
	input  wire logic                              disable_pin_level,
	input  wire logic                              thermal_high,
	// Programmed settings from the lower register bank
	input  wire logic [charger_pkg::CUR_W-1:0]     charge_current_setting,
	input  wire logic [charger_pkg::VFLOAT_W-1:0]  float_voltage_setting,
	// Controls to the analog loops
	output logic                                   aux_regulator_off,
	output logic                                   fixed_sense_target,
	output logic [charger_pkg::ADP_VREG_W-1:0]     adapter_input_regulation,
	output logic [charger_pkg::CUR_W-1:0]          charge_current_effective,
	output logic [charger_pkg::VFLOAT_W-1:0]       float_voltage_effective,
	output logic                                   thermal_foldback,
	// Interrupt
	output logic                                   irq
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int MON_W  = $bits(charger_pkg::monitor_t);
	localparam int SYNC_W = MON_W + 3;

	logic [SYNC_W-1:0]     raw_in;
	logic [SYNC_W-1:0]     sync_in;
	charger_pkg::monitor_t mon_s;
	logic                  adapter_s;
	logic                  dis_pin_s;
	logic                  therm_high_s;

	// Pins cross two flops; reads lag a pin by two cycles
	assign raw_in = {thermal_high, disable_pin_level, dedicated_adapter_detected, loop_status};

	sync2 #(
		.W (SYNC_W)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    (raw_in),
		.q    (sync_in)
	);

	assign mon_s        = charger_pkg::monitor_t'(sync_in[MON_W-1:0]);
	assign adapter_s    = sync_in[MON_W];
	assign dis_pin_s    = sync_in[MON_W+1];
	assign therm_high_s = sync_in[MON_W+2];

	// ----------------------------------------
	// Write channel state
	// ----------------------------------------
	logic                          aw_held_r, aw_held_nxt;
	logic                          w_held_r, w_held_nxt;
	logic [charger_pkg::IDX_W-1:0] aw_idx_r, aw_idx_nxt;
	logic [7:0]                    w_data_r, w_data_nxt;
	logic                          w_lane_r, w_lane_nxt;
	logic                          bvalid_r, bvalid_nxt;
	logic [1:0]                    bresp_r, bresp_nxt;
	logic                          wr_go;
	logic                          wr_hit;

	// Registers and interrupt state
	logic [7:0]                    adapter_r, adapter_nxt;
	charger_pkg::safety_t          safety_r, safety_nxt;
	logic [7:0]                    irq_stat_r, irq_stat_nxt;
	logic [7:0]                    irq_mask_r, irq_mask_nxt;
	charger_pkg::monitor_t         mon_prev_r;
	logic [7:0]                    mon_event;

	assign wr_go = aw_held_r && w_held_r && !bvalid_r;

	always_comb begin
		unique case (aw_idx_r)
			charger_pkg::IDX_ADAPTER,
			charger_pkg::IDX_SAFETY,
			charger_pkg::IDX_MONITOR,
			charger_pkg::IDX_IRQ_STAT,
			charger_pkg::IDX_IRQ_MASK,
			charger_pkg::IDX_PARAM_CMD: wr_hit = 1'b1;
			default:                    wr_hit = 1'b0;
		endcase
	end

	// Address and data may arrive in either order; each is held until both are in
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		aw_idx_nxt  = aw_idx_r;
		w_data_nxt  = w_data_r;
		w_lane_nxt  = w_lane_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			aw_idx_nxt  = s_axi_awaddr[charger_pkg::IDX_LSB +: charger_pkg::IDX_W];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt = 1'b1;
			w_data_nxt = s_axi_wdata[7:0];
			w_lane_nxt = s_axi_wstrb[0];
		end
		if (wr_go) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_hit ? charger_pkg::RESP_OKAY : charger_pkg::RESP_SLV;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_idx_r  <= '0;
			w_data_r  <= 8'h00;
			w_lane_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= charger_pkg::RESP_OKAY;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			aw_idx_r  <= aw_idx_nxt;
			w_data_r  <= w_data_nxt;
			w_lane_r  <= w_lane_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
		end
	end

	// ----------------------------------------
	// Register file update
	// ----------------------------------------
	logic wr_en;

	// Lane zero off drops the write, the answer is still OKAY for a mapped index
	assign wr_en     = wr_go && w_lane_r;
	// Either edge of a synced monitor bit is an event
	assign mon_event = mon_s ^ mon_prev_r;

	always_comb begin
		adapter_nxt  = adapter_r;
		safety_nxt   = safety_r;
		irq_mask_nxt = irq_mask_r;
		irq_stat_nxt = irq_stat_r;
		if (wr_en) begin
			unique case (aw_idx_r)
				charger_pkg::IDX_ADAPTER: begin
					// Only bits 6, 5 and 2:0 take the write
					adapter_nxt = w_data_r & charger_pkg::ADP_WR_MASK;
				end
				charger_pkg::IDX_SAFETY: begin
					safety_nxt          = charger_pkg::safety_t'(w_data_r);
					safety_nxt.reserved = 1'b0;
				end
				charger_pkg::IDX_IRQ_MASK: begin
					irq_mask_nxt = w_data_r;
				end
				charger_pkg::IDX_IRQ_STAT: begin
					irq_stat_nxt = irq_stat_r & ~w_data_r;
				end
				charger_pkg::IDX_PARAM_CMD: begin
					// Safety limits survive a parameter reset on purpose
					if (w_data_r[charger_pkg::PARAM_RST_BIT]) begin
						adapter_nxt = charger_pkg::ADP_RESET;
					end
				end
				default: begin
					// Monitor and unmapped writes change nothing
					adapter_nxt = adapter_r;
				end
			endcase
		end
		// A change arriving with a clear still sets its bit
		irq_stat_nxt = irq_stat_nxt | mon_event;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			adapter_r  <= charger_pkg::ADP_RESET;
			safety_r   <= charger_pkg::safety_t'(charger_pkg::SAFETY_RESET);
			irq_mask_r <= 8'h00;
			irq_stat_r <= 8'h00;
			mon_prev_r <= charger_pkg::monitor_t'(8'h00);
		end else begin
			adapter_r  <= adapter_nxt;
			safety_r   <= safety_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_stat_r <= irq_stat_nxt;
			mon_prev_r <= mon_s;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic                          rvalid_r, rvalid_nxt;
	logic [7:0]                    rdata_r, rdata_nxt;
	logic [1:0]                    rresp_r, rresp_nxt;
	logic [charger_pkg::IDX_W-1:0] ar_idx;
	logic [7:0]                    adapter_view;

	// Data captured at the address take, held until taken
	assign ar_idx = s_axi_araddr[charger_pkg::IDX_LSB +: charger_pkg::IDX_W];

	always_comb begin
		adapter_view                           = adapter_r;
		adapter_view[charger_pkg::ADP_ACTIVE]  = adapter_s;
		adapter_view[charger_pkg::ADP_DIS_PIN] = dis_pin_s;
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = charger_pkg::RESP_OKAY;
			unique case (ar_idx)
				charger_pkg::IDX_ADAPTER:   rdata_nxt = adapter_view;
				charger_pkg::IDX_SAFETY:    rdata_nxt = safety_r;
				charger_pkg::IDX_MONITOR:   rdata_nxt = mon_s;
				charger_pkg::IDX_IRQ_STAT:  rdata_nxt = irq_stat_r;
				charger_pkg::IDX_IRQ_MASK:  rdata_nxt = irq_mask_r;
				charger_pkg::IDX_PARAM_CMD: rdata_nxt = 8'h00;
				default: begin
					rdata_nxt = 8'h00;
					rresp_nxt = charger_pkg::RESP_SLV;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 8'h00;
			rresp_r  <= charger_pkg::RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	// ----------------------------------------
	// Analog controls and interrupt output
	// ----------------------------------------
	logic [charger_pkg::CUR_W-1:0]    cur_nxt;
	logic [charger_pkg::VFLOAT_W-1:0] vceil_ext;
	logic [charger_pkg::VFLOAT_W-1:0] vflt_nxt;

	// Ceiling code widens with zeros; code order tracks voltage order
	assign vceil_ext = {{(charger_pkg::VFLOAT_W - charger_pkg::VCEIL_W){1'b0}}, safety_r.float_voltage_ceiling};

	// Clamps act on raw codes, one cycle behind the inputs
	always_comb begin
		if (charge_current_setting > safety_r.charge_current_ceiling) begin
			cur_nxt = safety_r.charge_current_ceiling;
		end else begin
			cur_nxt = charge_current_setting;
		end
		if (float_voltage_setting > vceil_ext) begin
			vflt_nxt = vceil_ext;
		end else begin
			vflt_nxt = float_voltage_setting;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aux_regulator_off        <= 1'b0;
			fixed_sense_target       <= 1'b0;
			adapter_input_regulation <= '0;
			charge_current_effective <= '0;
			float_voltage_effective  <= '0;
			thermal_foldback         <= 1'b0;
			irq                      <= 1'b0;
			s_axi_awready            <= 1'b0;
			s_axi_wready             <= 1'b0;
			s_axi_arready            <= 1'b0;
		end else begin
			aux_regulator_off        <= adapter_nxt[charger_pkg::ADP_AUX_OFF];
			fixed_sense_target       <= adapter_nxt[charger_pkg::ADP_FIXED_SNS];
			adapter_input_regulation <= adapter_nxt[charger_pkg::ADP_VREG_LSB +: charger_pkg::ADP_VREG_W];
			charge_current_effective <= cur_nxt;
			float_voltage_effective  <= vflt_nxt;
			thermal_foldback         <= mon_s.thermal_regulation && !therm_high_s;
			// Next-state terms keep irq in step with the status bits
			irq                      <= |(irq_stat_nxt & irq_mask_nxt);
			// Readies fall on a take so no second request slips in
			s_axi_awready            <= !aw_held_nxt && !bvalid_nxt;
			s_axi_wready             <= !w_held_nxt && !bvalid_nxt;
			s_axi_arready            <= !rvalid_nxt;
		end
	end

	// Data above the low byte always reads as zero
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = {{(charger_pkg::DATA_W - 8){1'b0}}, rdata_r};

endmodule : charger_config_status_regs
`default_nettype wire

// ==== sim/charger_regs_props.sv ====
// Port checker for the charger register bank
`timescale 1ns/1ps
`default_nettype none
module charger_regs_props (
	// Clock and reset
	input wire logic                             mclk,
	input wire logic                             rst,
	// Bus
	input wire logic                             s_axi_arvalid,
	input wire logic                             s_axi_arready,
	input wire logic [7:0]                       s_axi_araddr,
	input wire logic                             s_axi_rvalid,
	input wire logic                             s_axi_rready,
	input wire logic [31:0]                      s_axi_rdata,
	input wire logic                             s_axi_bvalid,
	// Status and controls
	input wire charger_pkg::monitor_t            loop_status,
	input wire logic                             thermal_high,
	input wire logic [2:0]                       charge_current_setting,
	input wire logic [5:0]                       float_voltage_setting,
	input wire logic                             aux_regulator_off,
	input wire logic [2:0]                       charge_current_effective,
	input wire logic [5:0]                       float_voltage_effective,
	input wire logic                             thermal_foldback,
	input wire logic                             irq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire ar_hs = s_axi_arvalid && s_axi_arready;

	a_cur_ceiling: assert property ($stable(charge_current_setting)[*3] |->
		charge_current_effective <= charge_current_setting) else $error("charge current above setting");
	a_flt_ceiling: assert property ($stable(float_voltage_setting)[*3] |->
		float_voltage_effective <= float_voltage_setting) else $error("float voltage above setting");
	a_fold_high: assert property (thermal_high[*4] |-> !thermal_foldback)
		else $error("foldback with high thermal flag");
	a_mon_live: assert property ($stable(loop_status)[*4] ##0 ar_hs && s_axi_araddr == 8'h40 |=>
		s_axi_rdata == {24'h0, $past(loop_status)}) else $error("monitor read not live status");
	a_safe_bit7: assert property (ar_hs && s_axi_araddr == 8'h18 |=> !s_axi_rdata[7])
		else $error("safety bit 7 set");
	a_adp_bit7: assert property (ar_hs && s_axi_araddr == 8'h14 |=> !s_axi_rdata[7])
		else $error("adapter bit 7 set");
	a_aux_cause: assert property ($changed(aux_regulator_off) |-> ##[0:2] s_axi_bvalid)
		else $error("aux regulator moved without write");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");

	// Main scenarios, a reason to trust a quiet run
	c_mon_read: cover property (ar_hs && s_axi_araddr == 8'h40);
	c_irq_rise: cover property ($rose(irq));
	c_fold_fall: cover property ($fell(thermal_foldback));
endmodule : charger_regs_props

bind charger_config_status_regs charger_regs_props i_charger_regs_props (
	.mclk(mclk), .rst(rst), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .loop_status(loop_status),
	.thermal_high(thermal_high), .charge_current_setting(charge_current_setting),
	.float_voltage_setting(float_voltage_setting), .aux_regulator_off(aux_regulator_off),
	.charge_current_effective(charge_current_effective), .float_voltage_effective(float_voltage_effective),
	.thermal_foldback(thermal_foldback), .irq(irq));
`default_nettype wire

// ==== sim/tb_charger_config_status_regs.sv ====
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
`default_nettype none
module tb_charger_config_status_regs;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [1:0] OK = charger_pkg::RESP_OKAY;
	localparam logic [1:0] SE = charger_pkg::RESP_SLV;
	localparam logic [7:0] A_ADP = 8'h14, A_SAF = 8'h18, A_MON = 8'h40;
	localparam logic [7:0] A_IST = 8'h44, A_IMK = 8'h48, A_CMD = 8'h4c;
	logic                  mclk = 0, rst = 1, det = 0, dis = 0, thigh = 0;
	logic                  awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic                  awready, wready, bvalid, arready, rvalid, aux, fixd, fold, irq;
	logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]           wdata = 32'h0, rdata;
	logic [1:0]            bresp, rresp;
	logic [3:0]            wstrb = 4'hf;
	charger_pkg::monitor_t loop_status = 8'h00;
	logic [2:0]            cset = 3'h0, vreg, ceff;
	logic [5:0]            vset = 6'h00, veff;
	int                    error_cnt = 0, cmp_count = 0;

	charger_config_status_regs i_charger_config_status_regs (
		.mclk(mclk), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.loop_status(loop_status), .dedicated_adapter_detected(det), .disable_pin_level(dis),
		.thermal_high(thigh), .charge_current_setting(cset), .float_voltage_setting(vset),
		.aux_regulator_off(aux), .fixed_sense_target(fixd), .adapter_input_regulation(vreg),
		.charge_current_effective(ceff), .float_voltage_effective(veff), .thermal_foldback(fold), .irq(irq));

	always #50 mclk = ~mclk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task automatic tmo(input logic ok);
		if (!ok) begin
			error_cnt++;
			$display("unexpected at %0t: bus timeout", $time);
			wrap_up();
		end
	endtask : tmo

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask : wt

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int   n;
		logic pa, pw, dn;
		n = 0;
		pa = 1;
		pw = 1;
		dn = 0;
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= d;
		bready <= 1;
		while (!dn && n < 40) begin
			@(posedge mclk);
			n++;
			if (pa && awready) begin
				pa = 0;
				awvalid <= 0;
			end
			if (pw && wready) begin
				pw = 0;
				wvalid <= 0;
			end
			if (bvalid) begin
				dn = 1;
				bready <= 0;
				chk({30'h0, bresp}, {30'h0, er});
			end
		end
		tmo(dn);
		@(posedge mclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int   n;
		logic pa, dn;
		n = 0;
		pa = 1;
		dn = 0;
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		while (!dn && n < 40) begin
			@(posedge mclk);
			n++;
			if (pa && arready) begin
				pa = 0;
				arvalid <= 0;
			end
			if (rvalid) begin
				dn = 1;
				rready <= 0;
				chk(rdata, e);
				chk({30'h0, rresp}, {30'h0, er});
			end
		end
		tmo(dn);
		@(posedge mclk);
	endtask : rd

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		wt(20000);
		error_cnt++;
		wrap_up();
	end

	initial begin
		wt(8);
		rst <= 0;
		wt(2);
		rd(A_SAF, 32'h40, OK);
		rd(A_ADP, {24'h0, charger_pkg::ADP_RESET}, OK);
		chk({27'h0, aux, fixd, vreg}, 32'h0c);
		wr(A_ADP, 32'hff, OK);
		rd(A_ADP, {24'h0, charger_pkg::ADP_WR_MASK}, OK);
		chk({27'h0, aux, fixd, vreg}, 32'h1f);
		wr(A_ADP, 32'h00, OK);
		det <= 1;
		dis <= 1;
		wt(4);
		rd(A_ADP, 32'h18, OK);
		chk({27'h0, aux, fixd, vreg}, 32'h00);
		wr(A_SAF, 32'hff, OK);
		rd(A_SAF, 32'h7f, OK);
		wr(A_SAF, 32'h23, OK);
		cset <= 3'h5;
		vset <= 6'h3f;
		wt(3);
		chk({23'h0, ceff, veff}, {23'h0, 3'h2, 6'h03});
		cset <= 3'h1;
		vset <= 6'h02;
		wt(3);
		chk({23'h0, ceff, veff}, {23'h0, 3'h1, 6'h02});
		wr(A_CMD, 32'h01, OK);
		rd(A_ADP, 32'h3c, OK);
		rd(A_SAF, 32'h23, OK);
		for (int i = 0; i < 8; i++) begin
			loop_status <= 8'h01 << i;
			wt(4);
			rd(A_MON, 32'h1 << i, OK);
		end
		wr(A_MON, 32'h00, OK);
		rd(A_MON, 32'h80, OK);
		loop_status <= 8'h10;
		wt(4);
		chk({31'h0, fold}, 32'h1);
		thigh <= 1;
		wt(4);
		chk({31'h0, fold}, 32'h0);
		rd(8'h7c, 32'h0, SE);
		wr(8'h7c, 32'hff, SE);
		wr(A_IMK, 32'h01, OK);
		wr(A_IST, 32'hff, OK);
		chk({31'h0, irq}, 32'h0);
		loop_status <= 8'h12;
		wt(5);
		chk({31'h0, irq}, 32'h0);
		rd(A_IST, 32'h02, OK);
		loop_status <= 8'h13;
		wt(5);
		chk({31'h0, irq}, 32'h1);
		wr(A_IST, 32'h01, OK);
		wt(2);
		chk({31'h0, irq}, 32'h0);
		rd(A_IST, 32'h02, OK);
		wstrb <= 4'h0;
		wr(A_IMK, 32'hff, OK);
		wstrb <= 4'hf;
		rd(A_IMK, 32'h01, OK);
		rd(A_CMD, 32'h00, OK);
		wrap_up();
	end
endmodule : tb_charger_config_status_regs
`default_nettype wire
